/* rtl/ssr_pkg.sv */
// constants and types of the sequencer status register bank
package ssr_pkg;

    // register offsets on the serial management port
    localparam logic [7:0] OFS_CONTROL_PIN_STATE = 8'h13;
    localparam logic [7:0] OFS_ENABLE_DRIVE_STATE_HIGH = 8'h14;
    localparam logic [7:0] OFS_ENABLE_DRIVE_STATE_LOW = 8'h15;
    localparam logic [7:0] OFS_ENABLE_READBACK_HIGH = 8'h16;
    localparam logic [7:0] OFS_ENABLE_READBACK_LOW = 8'h17;
    localparam logic [7:0] OFS_WATCHDOG_STATUS = 8'h18;
    localparam logic [7:0] OFS_SELF_TEST_STATUS = 8'h19;
    localparam logic [7:0] OFS_LAST_RESET_CAUSE = 8'h1a;

    // reset value shared by unmapped reads and every register except control_pin_state, whose two output level bits read 1 at reset
    localparam logic [7:0] REG_RESET = 8'h00;

    // control_pin_state fields
    localparam int CPS_INTERRUPT_OUT_LEVEL = 5;
    localparam int CPS_RESET_OUT_LEVEL = 4;
    localparam int CPS_SLEEP_REQUEST_LEVEL = 3;
    localparam int CPS_RUN_REQUEST_LEVEL = 2;
    localparam int CPS_SEQUENCER_STATE_LSB = 0;

    // watchdog_status fields
    localparam int WDS_WINDOW_OPEN = 3;
    localparam int WDS_EARLY_SERVICE_FLAG = 1;
    localparam int WDS_TIMEOUT_FLAG = 0;

    // self_test_status fields
    localparam int STS_SELF_TEST_DONE = 6;
    localparam int STS_SINGLE_ERROR_CORRECTED = 5;
    localparam int STS_RESULT_LSB = 0;

    // last_reset_cause fields
    localparam int LRC_EXTERNAL_RESET_INPUT = 7;
    localparam int LRC_WATCHDOG_RESET_CAUSE = 6;
    localparam int LRC_EMERGENCY_POWERDOWN_INPUT = 4;
    localparam int LRC_RUN_LOW_SHUTDOWN_CAUSE = 3;
    localparam int LRC_WATCHDOG_SHUTDOWN_CAUSE = 2;
    localparam int LRC_CODE_LSB = 0;

    // sequencer state encodings
    localparam logic [1:0] SEQ_SHUTDOWN = 2'h0;
    localparam logic [1:0] SEQ_SLEEP = 2'h1;
    localparam logic [1:0] SEQ_INVALID = 2'h2;
    localparam logic [1:0] SEQ_ACTIVE = 2'h3;

    // number of enable channels
    localparam int EN_CHANNELS = 12;

    // levels carried from the sequencer clock into the register clock
    typedef struct packed {
        logic interrupt_drive_low;
        logic reset_drive_low;
        logic [1:0] sequencer_state;
        logic [EN_CHANNELS-1:0] enable_drive_bits;
        logic window_open;
        logic self_test_done;
        logic single_error_corrected;
        logic [3:0] self_test_fail;
    } ssr_levels_t;

    // serial port states
    typedef enum logic [3:0] {
        BUS_IDLE = 4'b0000,
        BUS_ADDR = 4'b0001,
        BUS_ACK_ADDR = 4'b0010,
        BUS_REG = 4'b0011,
        BUS_WR = 4'b0100,
        BUS_ACK_WR = 4'b0101,
        BUS_RD = 4'b0110,
        BUS_RD_ACK = 4'b0111,
        BUS_RD_LOAD = 4'b1000
    } ssr_bus_state_t;

endpackage : ssr_pkg

/* rtl/ssr_status_bank.sv */
// status register bank of the power sequencer with its serial read port
`timescale 1ns/1ps
module ssr_status_bank #(
    parameter logic [6:0] DEV_ADDR = 7'h38
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic seq_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic sleep_request_n,
    input wire logic run_request_input,
    input wire logic [ssr_pkg::EN_CHANNELS-1:0] enable_pin_level,
    input wire logic interrupt_drive_low,
    input wire logic system_reset_drive_low,
    input wire logic [1:0] sequencer_state,
    input wire logic [ssr_pkg::EN_CHANNELS-1:0] enable_drive_bits,
    input wire logic wd_window_open,
    input wire logic wd_early_event,
    input wire logic wd_expire_event,
    input wire logic self_test_done,
    input wire logic single_error_corrected,
    input wire logic [3:0] self_test_fail,
    input wire logic cause_capture,
    input wire logic cause_external_reset,
    input wire logic cause_watchdog_reset,
    input wire logic cause_emergency,
    input wire logic cause_run_low,
    input wire logic cause_watchdog_shutdown,
    input wire logic [1:0] forced_shutdown_code,
    input wire logic [1:0] watchdog_powerdown_mode,
    input wire logic emergency_sequence2
);
    import ssr_pkg::*;

    // sequencer clock domain state
    typedef struct packed {
        logic rst_m;
        logic rst_s;
        ssr_levels_t lvl;
        logic [1:0] ev_tog;
        logic req;
        logic ack_m;
        logic ack_s;
        logic [7:0] word;
        logic pend;
        logic [7:0] pend_word;
    } ssr_seq_state_t;

    // register clock domain state
    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_d;
        logic sda_m;
        logic sda_s;
        logic sda_d;
        logic slp_m;
        logic slp_s;
        logic run_m;
        logic run_s;
        logic [EN_CHANNELS-1:0] enp_m;
        logic [EN_CHANNELS-1:0] enp_s;
        ssr_levels_t lvl_m;
        ssr_levels_t lvl_s;
        logic [1:0] state_hold;
        logic [1:0] ev_m;
        logic [1:0] ev_s;
        logic [1:0] ev_d;
        logic req_m;
        logic req_s;
        logic ack;
        logic [7:0] cause;
        logic early_flag;
        logic timeout_flag;
        ssr_bus_state_t bus;
        logic [2:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic rw;
        logic oe;
        logic sda_q;
    } ssr_ref_state_t;

    ssr_seq_state_t sq;
    ssr_seq_state_t next_sq;
    ssr_ref_state_t st;
    ssr_ref_state_t next_st;

    // register read decode, used for the first byte and each following byte
    function automatic logic [7:0] read_reg(input logic [7:0] ofs, input ssr_ref_state_t s);
        logic [7:0] v;
        v = REG_RESET;
        unique case (ofs)
            OFS_CONTROL_PIN_STATE: begin
                v[CPS_INTERRUPT_OUT_LEVEL] = ~s.lvl_s.interrupt_drive_low;
                v[CPS_RESET_OUT_LEVEL] = ~s.lvl_s.reset_drive_low;
                v[CPS_SLEEP_REQUEST_LEVEL] = s.slp_s;
                v[CPS_RUN_REQUEST_LEVEL] = s.run_s;
                v[CPS_SEQUENCER_STATE_LSB +: 2] = s.state_hold;
            end
            OFS_ENABLE_DRIVE_STATE_HIGH: v[3:0] = s.lvl_s.enable_drive_bits[11:8];
            OFS_ENABLE_DRIVE_STATE_LOW: v = s.lvl_s.enable_drive_bits[7:0];
            OFS_ENABLE_READBACK_HIGH: v[3:0] = s.enp_s[11:8];
            OFS_ENABLE_READBACK_LOW: v = s.enp_s[7:0];
            OFS_WATCHDOG_STATUS: begin
                v[WDS_WINDOW_OPEN] = s.lvl_s.window_open;
                v[WDS_EARLY_SERVICE_FLAG] = s.early_flag;
                v[WDS_TIMEOUT_FLAG] = s.timeout_flag;
            end
            OFS_SELF_TEST_STATUS: begin
                v[STS_SELF_TEST_DONE] = s.lvl_s.self_test_done;
                v[STS_SINGLE_ERROR_CORRECTED] = s.lvl_s.single_error_corrected;
                v[STS_RESULT_LSB +: 4] = s.lvl_s.self_test_fail;
            end
            OFS_LAST_RESET_CAUSE: v = s.cause;
            default: v = REG_RESET;
        endcase
        return v;
    endfunction : read_reg

    // cause record composed from the sources of one event
    function automatic logic [7:0] compose_cause(
        input logic ext_rst,
        input logic wd_rst,
        input logic emerg,
        input logic run_low,
        input logic wd_shdn,
        input logic [1:0] code,
        input logic [1:0] pdmd
    );
        logic [7:0] v;
        v = REG_RESET;
        v[LRC_EXTERNAL_RESET_INPUT] = ext_rst;
        v[LRC_WATCHDOG_RESET_CAUSE] = wd_rst;
        v[LRC_EMERGENCY_POWERDOWN_INPUT] = emerg;
        v[LRC_RUN_LOW_SHUTDOWN_CAUSE] = run_low;
        v[LRC_WATCHDOG_SHUTDOWN_CAUSE] = wd_shdn;
        v[LRC_CODE_LSB +: 2] = wd_shdn ? pdmd : code;
        return v;
    endfunction : compose_cause

    // sequencer side: level capture, event toggles, cause handshake
    always_comb begin
        next_sq = sq;
        next_sq.rst_m = reset;
        next_sq.rst_s = sq.rst_m;
        next_sq.ack_m = st.ack;
        next_sq.ack_s = sq.ack_m;
        if (sq.rst_s) begin
            next_sq.lvl = '0;
            next_sq.ev_tog = 2'h0;
            next_sq.req = 1'b0;
            next_sq.word = REG_RESET;
            next_sq.pend = 1'b0;
            next_sq.pend_word = REG_RESET;
        end else begin
            next_sq.lvl.interrupt_drive_low = interrupt_drive_low;
            next_sq.lvl.reset_drive_low = system_reset_drive_low;
            next_sq.lvl.sequencer_state = sequencer_state;
            next_sq.lvl.enable_drive_bits = enable_drive_bits;
            next_sq.lvl.window_open = wd_window_open;
            next_sq.lvl.self_test_done = self_test_done;
            next_sq.lvl.single_error_corrected = single_error_corrected;
            next_sq.lvl.self_test_fail = self_test_fail;
            next_sq.ev_tog[WDS_EARLY_SERVICE_FLAG] = sq.ev_tog[1] ^ wd_early_event;
            next_sq.ev_tog[WDS_TIMEOUT_FLAG] = sq.ev_tog[0] ^ wd_expire_event;
            // sequence 2 emergency is left to the interrupt source flag
            if (cause_capture && !emergency_sequence2) begin
                next_sq.pend = 1'b1;
                next_sq.pend_word = compose_cause(cause_external_reset, cause_watchdog_reset,
                    cause_emergency, cause_run_low, cause_watchdog_shutdown,
                    forced_shutdown_code, watchdog_powerdown_mode);
            end
            // word changes only while the previous one has been taken over
            if (next_sq.pend && (sq.req == sq.ack_s)) begin
                next_sq.word = next_sq.pend_word;
                next_sq.req = ~sq.req;
                next_sq.pend = 1'b0;
            end
        end
    end

    always_ff @(posedge seq_clk) begin
        sq <= next_sq;
    end

    // register side: synchronisers, flags and serial port
    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_c;
        logic stop_c;
        logic [7:0] byte_in;
        logic [7:0] rd_byte;
        logic [1:0] ev_edge;
        logic clr_wd;
        scl_rise = st.scl_s & ~st.scl_d;
        scl_fall = ~st.scl_s & st.scl_d;
        start_c = st.scl_s & st.scl_d & st.sda_d & ~st.sda_s;
        stop_c = st.scl_s & st.scl_d & ~st.sda_d & st.sda_s;
        byte_in = {st.shreg[6:0], st.sda_s};
        rd_byte = read_reg(st.ptr, st);
        ev_edge = st.ev_s ^ st.ev_d;
        clr_wd = 1'b0;

        next_st = st;
        next_st.scl_m = scl_in;
        next_st.scl_s = st.scl_m;
        next_st.scl_d = st.scl_s;
        next_st.sda_m = sda_in;
        next_st.sda_s = st.sda_m;
        next_st.sda_d = st.sda_s;
        next_st.slp_m = sleep_request_n;
        next_st.slp_s = st.slp_m;
        next_st.run_m = run_request_input;
        next_st.run_s = st.run_m;
        next_st.enp_m = enable_pin_level;
        next_st.enp_s = st.enp_m;
        next_st.lvl_m = sq.lvl;
        next_st.lvl_s = st.lvl_m;
        next_st.ev_m = sq.ev_tog;
        next_st.ev_s = st.ev_m;
        next_st.ev_d = st.ev_s;
        next_st.req_m = sq.req;
        next_st.req_s = st.req_m;
        next_st.sda_q = 1'b0;

        // an invalid code seen mid-transition keeps the last valid state
        if (st.lvl_s.sequencer_state != SEQ_INVALID) begin
            next_st.state_hold = st.lvl_s.sequencer_state;
        end
        // take over a new cause record, then acknowledge it
        if (st.req_s != st.ack) begin
            next_st.cause = sq.word;
            next_st.ack = st.req_s;
        end

        unique case (st.bus)
            BUS_IDLE: ;
            BUS_ADDR: if (scl_rise) begin
                next_st.shreg = byte_in;
                next_st.bitcnt = st.bitcnt + 3'h1;
                if (st.bitcnt == 3'h7) begin
                    next_st.rw = st.sda_s;
                    next_st.bus = (byte_in[7:1] == DEV_ADDR) ? BUS_ACK_ADDR : BUS_IDLE;
                end
            end
            BUS_ACK_ADDR: if (scl_fall) begin
                if (!st.oe) begin
                    next_st.oe = 1'b1;
                end else if (st.rw) begin
                    next_st.oe = ~rd_byte[7];
                    next_st.shreg = {rd_byte[6:0], 1'b0};
                    next_st.ptr = st.ptr + 8'h01;
                    clr_wd = (st.ptr == OFS_WATCHDOG_STATUS);
                    next_st.bitcnt = 3'h0;
                    next_st.bus = BUS_RD;
                end else begin
                    next_st.oe = 1'b0;
                    next_st.bitcnt = 3'h0;
                    next_st.bus = BUS_REG;
                end
            end
            BUS_REG, BUS_WR: if (scl_rise) begin
                next_st.shreg = byte_in;
                next_st.bitcnt = st.bitcnt + 3'h1;
                if (st.bitcnt == 3'h7) begin
                    // data bytes are acknowledged and dropped
                    if (st.bus == BUS_REG) begin
                        next_st.ptr = byte_in;
                    end
                    next_st.bus = BUS_ACK_WR;
                end
            end
            BUS_ACK_WR: if (scl_fall) begin
                next_st.oe = ~st.oe;
                if (st.oe) begin
                    next_st.bitcnt = 3'h0;
                    next_st.bus = BUS_WR;
                end
            end
            BUS_RD: if (scl_fall) begin
                if (st.bitcnt == 3'h7) begin
                    next_st.oe = 1'b0;
                    next_st.bus = BUS_RD_ACK;
                end else begin
                    next_st.oe = ~st.shreg[7];
                    next_st.shreg = {st.shreg[6:0], 1'b0};
                    next_st.bitcnt = st.bitcnt + 3'h1;
                end
            end
            BUS_RD_ACK: if (scl_rise) begin
                next_st.bus = st.sda_s ? BUS_IDLE : BUS_RD_LOAD;
            end
            BUS_RD_LOAD: if (scl_fall) begin
                next_st.oe = ~rd_byte[7];
                next_st.shreg = {rd_byte[6:0], 1'b0};
                next_st.ptr = st.ptr + 8'h01;
                clr_wd = (st.ptr == OFS_WATCHDOG_STATUS);
                next_st.bitcnt = 3'h0;
                next_st.bus = BUS_RD;
            end
            default: next_st.bus = BUS_IDLE;
        endcase

        // start and stop override any byte in progress
        if (start_c) begin
            next_st.bus = BUS_ADDR;
            next_st.bitcnt = 3'h0;
            next_st.oe = 1'b0;
        end else if (stop_c) begin
            next_st.bus = BUS_IDLE;
            next_st.oe = 1'b0;
        end

        // clear on read; an event in the same cycle still sets
        next_st.early_flag = (st.early_flag & ~clr_wd) | ev_edge[1];
        next_st.timeout_flag = (st.timeout_flag & ~clr_wd) | ev_edge[0];

        if (reset) begin
            next_st = '0;
            next_st.bus = BUS_IDLE;
            next_st.cause = REG_RESET;
            next_st.state_hold = SEQ_SHUTDOWN;
        end
    end

    always_ff @(posedge ref_clk) begin
        st <= next_st;
    end

    assign sda_out = st.sda_q;
    assign sda_oe = st.oe;

endmodule : ssr_status_bank

/* test/ssr_host_model.sv */
// host processor model that reads the bank over the serial port
`timescale 1ns/1ps
module ssr_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h38
) (
    input wire logic ref_clk,
    input wire logic sda_oe,
    output logic scl,
    output logic sda_line
);
    logic sda_drv;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // pulled-up line, low when either side pulls it
    assign sda_line = sda_drv & ~sda_oe;
    task automatic half();
        repeat (12) @(posedge ref_clk);
    endtask : half
    task automatic bit_io(input logic b, output logic r);
        @(posedge ref_clk);
        sda_drv <= b;
        half();
        scl <= 1'b1;
        half();
        r = sda_line;
        scl <= 1'b0;
    endtask : bit_io
    task automatic start();
        @(posedge ref_clk);
        sda_drv <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sda_drv <= 1'b0;
        half();
        scl <= 1'b0;
    endtask : start
    task automatic stop();
        @(posedge ref_clk);
        sda_drv <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sda_drv <= 1'b1;
        half();
    endtask : stop
    task automatic byte_io(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                           output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(mack, ack);
    endtask : byte_io
    // two-byte read with auto-increment, nak high if any address or pointer byte refused
    task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d0, output logic [7:0] d1,
                            output logic nak);
        logic [7:0] x;
        logic a0, a1, a2, a3;
        start();
        byte_io({DEV_ADDR, 1'b0}, 1'b1, x, a0);
        byte_io(ofs, 1'b1, x, a1);
        start();
        byte_io({DEV_ADDR, 1'b1}, 1'b1, x, a2);
        byte_io(8'hff, 1'b0, d0, a3);
        byte_io(8'hff, 1'b1, d1, a3);
        stop();
        nak = a0 | a1 | a2;
    endtask : read_reg
    task automatic write_reg(input logic [6:0] addr, input logic [7:0] ofs,
                             input logic [7:0] d, output logic nak);
        logic [7:0] x;
        logic a0, a1, a2;
        start();
        byte_io({addr, 1'b0}, 1'b1, x, a0);
        byte_io(ofs, 1'b1, x, a1);
        byte_io(d, 1'b1, x, a2);
        stop();
        nak = a0 | a1 | a2;
    endtask : write_reg
endmodule : ssr_host_model

/* test/ssr_monitor.sv */
// protocol checker for the serial port of the status register bank
`timescale 1ns/1ps
module ssr_monitor #(
    parameter logic [6:0] DEV_ADDR = 7'h38
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe
);
    logic scl_q, sda_q, first, hit, ign;
    logic [3:0] nbit;
    logic [7:0] sh;
    logic [7:0] next_sh;
    logic start_seen, rise_seen;
    assign next_sh = {sh[6:0], sda_in};
    assign start_seen = scl_q & scl_in & sda_q & ~sda_in;
    assign rise_seen = ~scl_q & scl_in;
    // bit counter, shift register and address match of the current frame
    always_ff @(posedge ref_clk) begin
        scl_q <= scl_in;
        sda_q <= sda_in;
        if (reset) begin
            nbit <= 4'h0;
            sh <= 8'h00;
            first <= 1'b0;
            hit <= 1'b0;
            ign <= 1'b0;
        end else if (start_seen) begin
            nbit <= 4'h0;
            first <= 1'b1;
            hit <= 1'b0;
            ign <= 1'b0;
        end else if (rise_seen) begin
            sh <= next_sh;
            nbit <= (nbit == 4'h8) ? 4'h0 : nbit + 4'h1;
            first <= first && nbit != 4'h8;
            hit <= first && nbit == 4'h7 && next_sh[7:1] == DEV_ADDR;
            ign <= ign || (first && nbit == 4'h7 && next_sh[7:1] != DEV_ADDR);
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_sda_out_low: assert property (sda_out == 1'b0)
        else $error("sda_out not held low");
    a_reset_quiet: assert property ($fell(reset) |-> !sda_oe [*8])
        else $error("line driven right after reset");
    a_drive_after_fall: assert property ($rose(sda_oe) |-> !scl_in && $past(scl_in, 8))
        else $error("line pulled low outside the answer slot");
    a_release_scl_low: assert property ($fell(sda_oe) |-> !scl_in)
        else $error("line released while clock high");
    a_steady_scl_high: assert property ($rose(scl_in) |=> $stable(sda_oe) [*6])
        else $error("line changed while clock high");
    a_address_ack: assert property (hit && $fell(scl_in) |-> ##[1:8] sda_oe)
        else $error("own address not acknowledged");
    a_foreign_quiet: assert property (ign |-> !sda_oe)
        else $error("line driven for a foreign address");
    a_addr_phase_quiet: assert property (first && nbit != 4'h8 |-> !sda_oe)
        else $error("line driven during address bits");
    c_address_ack: cover property (hit && $fell(scl_in));
    c_foreign: cover property (ign);
    c_data_drive: cover property ($rose(sda_oe) && !hit);
endmodule : ssr_monitor

bind ssr_status_bank ssr_monitor #(.DEV_ADDR(DEV_ADDR)) i_ssr_monitor (
    .ref_clk(ref_clk),
    .reset(reset),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe)
);

/* test/test_ssr_status_bank.sv */
// self-checking bench of the sequencer status register bank
`timescale 1ns/1ps
module test_ssr_status_bank;
    import ssr_pkg::*;
    logic ref_clk = 1'b0;
    logic seq_clk = 1'b0;
    logic reset = 1'b1;
    logic scl_in, sda_in, sda_out, sda_oe, nak;
    logic sleep_request_n = 1'b0, run_request_input = 1'b0, wd_window_open = 1'b0;
    logic interrupt_drive_low = 1'b1, system_reset_drive_low = 1'b1;
    logic [1:0] sequencer_state = 2'h0;
    logic [11:0] enable_pin_level = 12'h000, enable_drive_bits = 12'h000;
    logic wd_early_event = 1'b0, wd_expire_event = 1'b0, cause_capture = 1'b0;
    logic self_test_done = 1'b0, single_error_corrected = 1'b0;
    logic [3:0] self_test_fail = 4'h0;
    logic cause_external_reset = 1'b0, cause_watchdog_reset = 1'b0, cause_emergency = 1'b0;
    logic cause_run_low = 1'b0, cause_watchdog_shutdown = 1'b0, emergency_sequence2 = 1'b0;
    logic [1:0] forced_shutdown_code = 2'h0, watchdog_powerdown_mode = 2'h0;
    logic [7:0] d0, d1;
    int n_mismatch = 0;
    int n_compared = 0;
    always #2.5 ref_clk = ~ref_clk;
    always #6 seq_clk = ~seq_clk;
    ssr_status_bank #(.DEV_ADDR(7'h38)) i_ssr_status_bank (
        .ref_clk(ref_clk), .reset(reset), .seq_clk(seq_clk),
        .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
        .sleep_request_n(sleep_request_n), .run_request_input(run_request_input),
        .enable_pin_level(enable_pin_level), .interrupt_drive_low(interrupt_drive_low),
        .system_reset_drive_low(system_reset_drive_low), .sequencer_state(sequencer_state),
        .enable_drive_bits(enable_drive_bits), .wd_window_open(wd_window_open),
        .wd_early_event(wd_early_event), .wd_expire_event(wd_expire_event),
        .self_test_done(self_test_done), .single_error_corrected(single_error_corrected),
        .self_test_fail(self_test_fail), .cause_capture(cause_capture),
        .cause_external_reset(cause_external_reset),
        .cause_watchdog_reset(cause_watchdog_reset), .cause_emergency(cause_emergency),
        .cause_run_low(cause_run_low), .cause_watchdog_shutdown(cause_watchdog_shutdown),
        .forced_shutdown_code(forced_shutdown_code),
        .watchdog_powerdown_mode(watchdog_powerdown_mode),
        .emergency_sequence2(emergency_sequence2)
    );
    ssr_host_model #(.DEV_ADDR(7'h38)) i_ssr_host_model (
        .ref_clk(ref_clk),
        .sda_oe(sda_oe),
        .scl(scl_in),
        .sda_line(sda_in)
    );
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] ofs, input logic [7:0] e0, input logic [7:0] e1);
        i_ssr_host_model.read_reg(ofs, d0, d1, nak);
        chk({7'h00, nak}, 8'h00);
        chk(d0, e0);
        chk(d1, e1);
    endtask : rd
    task automatic settle();
        repeat (24) @(posedge ref_clk);
    endtask : settle
    task automatic pulse(input int k);
        @(posedge seq_clk);
        wd_early_event <= (k == 0);
        wd_expire_event <= (k == 1);
        cause_capture <= (k == 2);
        @(posedge seq_clk);
        {wd_early_event, wd_expire_event, cause_capture} <= 3'b000;
        settle();
    endtask : pulse
    task automatic t_power_on();
        rd(OFS_SELF_TEST_STATUS, 8'h00, 8'h00);
        rd(OFS_CONTROL_PIN_STATE, 8'h00, 8'h00);
        rd(OFS_ENABLE_DRIVE_STATE_LOW, 8'h00, 8'h00);
        rd(OFS_ENABLE_READBACK_LOW, 8'h00, 8'h00);
        $display("test power_on finished");
    endtask : t_power_on
    task automatic t_control();
        logic [5:0] s [4] = '{6'b001111, 6'b100100, 6'b011001, 6'b011010};
        logic [7:0] e [4] = '{8'h3f, 8'h14, 8'h29, 8'h29};
        for (int i = 0; i < 4; i++) begin
            @(posedge seq_clk);
            {interrupt_drive_low, system_reset_drive_low, sleep_request_n,
             run_request_input, sequencer_state} <= s[i];
            settle();
            rd(OFS_CONTROL_PIN_STATE, e[i], 8'h00);
        end
        $display("test control finished");
    endtask : t_control
    task automatic t_enable();
        logic [11:0] dv, pv;
        for (int i = 0; i < 2; i++) begin
            dv = i ? 12'h5a3 : 12'ha5c;
            pv = i ? 12'hc36 : 12'h3c9;
            @(posedge seq_clk);
            enable_drive_bits <= dv;
            enable_pin_level <= pv;
            settle();
            rd(OFS_ENABLE_DRIVE_STATE_HIGH, {4'h0, dv[11:8]}, dv[7:0]);
            rd(OFS_ENABLE_READBACK_HIGH, {4'h0, pv[11:8]}, pv[7:0]);
        end
        $display("test enable finished");
    endtask : t_enable
    task automatic t_watchdog();
        @(posedge seq_clk);
        wd_window_open <= 1'b1;
        pulse(0);
        rd(OFS_WATCHDOG_STATUS, 8'h0a, 8'h00);
        rd(OFS_WATCHDOG_STATUS, 8'h08, 8'h00);
        @(posedge seq_clk);
        wd_window_open <= 1'b0;
        pulse(1);
        i_ssr_host_model.write_reg(7'h38, OFS_WATCHDOG_STATUS, 8'hff, nak);
        chk({7'h00, nak}, 8'h00);
        rd(OFS_WATCHDOG_STATUS, 8'h01, 8'h00);
        rd(OFS_WATCHDOG_STATUS, 8'h00, 8'h00);
        $display("test watchdog finished");
    endtask : t_watchdog
    task automatic t_self_test();
        logic [5:0] s [2] = '{6'b111010, 6'b000101};
        logic [7:0] e [2] = '{8'h6a, 8'h05};
        for (int i = 0; i < 2; i++) begin
            @(posedge seq_clk);
            {self_test_done, single_error_corrected, self_test_fail} <= s[i];
            settle();
            rd(OFS_SELF_TEST_STATUS, e[i], 8'h00);
        end
        $display("test self_test finished");
    endtask : t_self_test
    task automatic t_cause();
        logic [9:0] s [7] = '{10'h200, 10'h100, 10'h080, 10'h040, 10'h02c, 10'h01a, 10'h081};
        logic [7:0] e [7] = '{8'h80, 8'h40, 8'h10, 8'h08, 8'h06, 8'h03, 8'h03};
        for (int i = 0; i < 7; i++) begin
            @(posedge seq_clk);
            {cause_external_reset, cause_watchdog_reset, cause_emergency, cause_run_low,
             cause_watchdog_shutdown, forced_shutdown_code, watchdog_powerdown_mode,
             emergency_sequence2} <= s[i];
            pulse(2);
            rd(OFS_LAST_RESET_CAUSE, e[i], 8'h00);
        end
        $display("test cause finished");
    endtask : t_cause
    task automatic t_refuse();
        i_ssr_host_model.write_reg(7'h39, OFS_CONTROL_PIN_STATE, 8'hff, nak);
        chk({7'h00, nak}, 8'h01);
        rd(OFS_LAST_RESET_CAUSE, 8'h03, 8'h00);
        $display("test refuse finished");
    endtask : t_refuse
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (20) @(posedge ref_clk);
        t_power_on();
        t_control();
        t_enable();
        t_watchdog();
        t_self_test();
        t_cause();
        t_refuse();
        test_done();
    end
    initial begin
        repeat (80000) @(posedge ref_clk);
        n_mismatch++;
        test_done();
    end
endmodule : test_ssr_status_bank
